/* File: src/catsc_top.sv */
// Analog tweak and headphone short control register bank
`timescale 1ns/10ps
module catsc_top #(
    parameter int unsigned TIMEOUT_CYCLES = catsc_pkg::SHORT_TIMEOUT_CYC
) (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [15:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [15:0]                  reg_rdata,
    input  wire logic                         short_left_async,
    input  wire logic                         short_right_async,
    input  wire logic                         short_center_async,
    input  wire logic                         dac_in_valid,
    input  wire logic [catsc_pkg::DAC_W-1:0]  dac_in_left,
    input  wire logic [catsc_pkg::DAC_W-1:0]  dac_in_right,
    output logic                              dac_out_valid,
    output logic      [catsc_pkg::DAC_W-1:0]  dac_out_left,
    output logic      [catsc_pkg::DAC_W-1:0]  dac_out_right,
    output catsc_pkg::catsc_analog_s          analog_ctrl,
    output logic                              retune_pulse,
    output catsc_pkg::catsc_trip_s            trip_level,
    output logic                              left_class_a,
    output logic                              right_class_a,
    output logic                              side_short_flag
);

    // ------------------------------------------------------------
    // Trip level decoding
    // ------------------------------------------------------------
    // Codes 3..0 count upward from the smallest step, codes 4..7 continue past code 0
    function automatic logic [3:0] trip_steps(input logic [2:0] code);
        trip_steps = code[2] ? ({1'b0, code} + 4'h1) : (4'h4 - {1'b0, code});
    endfunction

    localparam int TIMER_BITS = catsc_pkg::TIMER_W;

    catsc_pkg::catsc_state_s s_r;
    catsc_pkg::catsc_state_s s_nxt;
    catsc_pkg::catsc_mode_e  mode;
    logic                    detect_on;
    logic                    expire;
    logic                    wr_tweaks;
    logic                    wr_short;
    logic                    raw_left;
    logic                    raw_right;
    logic                    raw_center;
    logic                    flag_now;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt      = s_r;
        mode       = catsc_pkg::catsc_mode_e'(s_r.short_ctrl[catsc_pkg::POS_SIDE_MODE +: 2]);
        raw_left   = s_r.sync2[0];
        raw_right  = s_r.sync2[1];
        raw_center = s_r.sync2[2];
        wr_tweaks  = reg_wr && (reg_addr == catsc_pkg::OFS_ANA_TWEAKS);
        wr_short   = reg_wr && (reg_addr == catsc_pkg::OFS_SHORT_CTRL);

        // Pin inputs: second stage is the only reader of the first
        s_nxt.sync1 = {short_center_async, short_right_async, short_left_async};
        s_nxt.sync2 = s_r.sync1;

        // Reserved bits masked off so they read zero
        if (wr_tweaks) begin
            s_nxt.tweaks = reg_wdata & catsc_pkg::MASK_ANA_TWEAKS;
        end
        if (wr_short) begin
            s_nxt.short_ctrl = reg_wdata & catsc_pkg::MASK_SHORT_CTRL;
        end

        // Retune fires on the write that takes the bit from high to low
        s_nxt.retune_pulse = wr_tweaks && s_r.tweaks[catsc_pkg::POS_RETUNE]
                             && !reg_wdata[catsc_pkg::POS_RETUNE];

        // Mode 2 is treated as off so a bad write cannot leave a stuck latch
        detect_on = (mode == catsc_pkg::SIDE_MODE_TIMED) ||
                    (mode == catsc_pkg::SIDE_MODE_MANUAL);

        // Off and invalid modes show the live synchronised signal, timed and manual modes the latch
        flag_now  = detect_on ? (s_r.latch_left || s_r.latch_right)
                              : (raw_left || raw_right);

        // Timeout counter runs only in timed mode
        expire = 1'b0;
        if (mode == catsc_pkg::SIDE_MODE_TIMED) begin
            if (s_r.timer >= TIMER_BITS'(TIMEOUT_CYCLES - 1)) begin
                expire      = 1'b1;
                s_nxt.timer = '0;
            end else begin
                s_nxt.timer = s_r.timer + TIMER_BITS'(1);
            end
        end else begin
            s_nxt.timer = '0;
        end

        // A short seen in the clearing cycle keeps the latch set
        if (!detect_on) begin
            s_nxt.latch_left  = 1'b0;
            s_nxt.latch_right = 1'b0;
        end else begin
            s_nxt.latch_left  = raw_left  || (s_r.latch_left  && !expire);
            s_nxt.latch_right = raw_right || (s_r.latch_right && !expire);
        end

        // Mono copy at the DAC sample register
        s_nxt.dac_valid = dac_in_valid;
        if (dac_in_valid) begin
            s_nxt.dac_left  = dac_in_left;
            s_nxt.dac_right = s_r.tweaks[catsc_pkg::POS_MONO] ? dac_in_left
                                                              : dac_in_right;
        end

        // Read data stands only in the cycle after the strobe
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                catsc_pkg::OFS_ANA_TWEAKS: begin
                    s_nxt.rdata = s_r.tweaks;
                end
                catsc_pkg::OFS_SHORT_CTRL: begin
                    s_nxt.rdata = s_r.short_ctrl;
                end
                catsc_pkg::OFS_ANA_STATUS: begin
                    s_nxt.rdata[catsc_pkg::POS_SIDE_FLAG]   = flag_now;
                    s_nxt.rdata[catsc_pkg::POS_CENTER_FLAG] = raw_center;
                end
                default: begin
                    s_nxt.rdata = 16'h0000;
                end
            endcase
        end

        if (reset) begin
            s_nxt              = '0;
            s_nxt.tweaks       = catsc_pkg::RST_ANA_TWEAKS;
            s_nxt.short_ctrl   = catsc_pkg::RST_SHORT_CTRL;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Analog controls are the register bits themselves, no extra delay
    assign analog_ctrl = catsc_pkg::catsc_analog_s'(
        s_r.tweaks[14:0]);

    assign trip_level.right_ma  = 8'(trip_steps(s_r.short_ctrl[catsc_pkg::POS_RIGHT_TRIP +: 3])
                                     * 8'd25);
    assign trip_level.left_ma   = 8'(trip_steps(s_r.short_ctrl[catsc_pkg::POS_LEFT_TRIP +: 3])
                                     * 8'd25);
    assign trip_level.center_ma = 9'(trip_steps(s_r.short_ctrl[catsc_pkg::POS_CENTER_TRIP +: 3])
                                     * 9'd50);

    // Class A forcing limits current while a side is latched shorted
    assign left_class_a  = s_r.latch_left;
    assign right_class_a = s_r.latch_right;

    // Flag is formed once in the next-state process so the read path sees no loop
    assign side_short_flag = flag_now;

    assign retune_pulse  = s_r.retune_pulse;
    assign dac_out_valid = s_r.dac_valid;
    assign dac_out_left  = s_r.dac_left;
    assign dac_out_right = s_r.dac_right;
    assign reg_rdata     = s_r.rdata;

endmodule

/* File: src/catsc_pkg.sv */
// Constants and types for the analog test and headphone short control block
package catsc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_ANA_STATUS  = 8'h36;
    localparam logic [7:0]  OFS_ANA_TWEAKS  = 8'h3a;
    localparam logic [7:0]  OFS_SHORT_CTRL  = 8'h3c;
    localparam logic [15:0] RST_ANA_TWEAKS  = 16'h0000;
    localparam logic [15:0] RST_SHORT_CTRL  = 16'h0000;
    localparam logic [15:0] MASK_ANA_TWEAKS = 16'h7fff;
    localparam logic [15:0] MASK_SHORT_CTRL = 16'h777c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_MONO        = 12;
    localparam int POS_RETUNE      = 11;
    localparam int POS_RIGHT_TRIP  = 12;
    localparam int POS_LEFT_TRIP   = 8;
    localparam int POS_CENTER_TRIP = 4;
    localparam int POS_SIDE_MODE   = 2;
    localparam int POS_SIDE_FLAG   = 9;
    localparam int POS_CENTER_FLAG = 8;

    // ------------------------------------------------------------
    // Timing and widths
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_HZ         = 50_000_000;
    localparam int unsigned SHORT_TIMEOUT_MS = 50;
    localparam int unsigned SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_MS * (CLOCK_HZ / 1000);
    localparam int          TIMER_W          = 32;
    localparam int          DAC_W            = 24;

    typedef enum logic [1:0] {
        SIDE_MODE_OFF     = 2'b00,
        SIDE_MODE_TIMED   = 2'b01,
        SIDE_MODE_INVALID = 2'b10,
        SIDE_MODE_MANUAL  = 2'b11
    } catsc_mode_e;

    // Field order follows register bits 14 down to 0
    typedef struct packed {
        logic lineout_supply_vdda;
        logic spare_to_analog;
        logic mono_copy_left;
        logic oscillator_retune;
        logic tie_reference_nodes;
        logic dac_sample_edge_flip;
        logic dac_crossing_edge_flip;
        logic dac_rz_lengthen;
        logic dac_double_current;
        logic dac_rz_off;
        logic dac_amp_no_ab;
        logic adc_sample_edge_flip;
        logic adc_crossing_edge_flip;
        logic adc_bias_reduce;
        logic dither_off_a;
    } catsc_analog_s;

    typedef struct packed {
        logic [7:0] right_ma;
        logic [7:0] left_ma;
        logic [8:0] center_ma;
    } catsc_trip_s;

    typedef struct packed {
        logic [15:0]        tweaks;
        logic [15:0]        short_ctrl;
        logic [2:0]         sync1;
        logic [2:0]         sync2;
        logic               latch_left;
        logic               latch_right;
        logic [TIMER_W-1:0] timer;
        logic               retune_pulse;
        logic               dac_valid;
        logic [DAC_W-1:0]   dac_left;
        logic [DAC_W-1:0]   dac_right;
        logic [15:0]        rdata;
    } catsc_state_s;

endpackage

/* File: verif/catsc_checker.sv */
// Port checker for the analog tweak and headphone short control bank
`timescale 1ns/10ps
module catsc_checker #(
    parameter int unsigned TIMEOUT_CYCLES = 20
) (
    input wire logic                        clock,
    input wire logic                        reset,
    input wire logic [7:0]                  reg_addr,
    input wire logic [15:0]                 reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [15:0]                 reg_rdata,
    input wire logic                        short_left_async,
    input wire logic                        short_right_async,
    input wire logic                        dac_in_valid,
    input wire logic [catsc_pkg::DAC_W-1:0] dac_in_left,
    input wire logic [catsc_pkg::DAC_W-1:0] dac_in_right,
    input wire logic [catsc_pkg::DAC_W-1:0] dac_out_right,
    input wire catsc_pkg::catsc_analog_s    analog_ctrl,
    input wire logic                        retune_pulse,
    input wire catsc_pkg::catsc_trip_s      trip_level,
    input wire logic                        left_class_a,
    input wire logic                        right_class_a,
    input wire logic                        side_short_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Code 0 sits mid-scale, so the step count folds round at code 4
    function automatic logic [8:0] ma(logic [2:0] c, int s);
        return (c < 3'h4) ? 9'((4 - c) * s) : 9'((c + 1) * s);
    endfunction
    sequence tw_wr; reg_wr && reg_addr == 8'h3a; endsequence
    sequence sc_wr; reg_wr && reg_addr == 8'h3c; endsequence
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    AST_TW_READ: assert property (reg_rd && reg_addr == 8'h3a
        |=> reg_rdata == {1'b0, analog_ctrl}) else $error("tweak readback wrong");
    AST_TW_WRITE: assert property (tw_wr |=> analog_ctrl == $past(reg_wdata[14:0]))
        else $error("tweak bits not applied");
    AST_MONO: assert property ($past(dac_in_valid && analog_ctrl.mono_copy_left)
        |-> dac_out_right == $past(dac_in_left)) else $error("mono copy wrong");
    AST_STEREO: assert property ($past(dac_in_valid && !analog_ctrl.mono_copy_left)
        |-> dac_out_right == $past(dac_in_right)) else $error("right sample wrong");
    AST_RETUNE: assert property (retune_pulse |-> $past(reg_wr && reg_addr == 8'h3a
        && !reg_wdata[11]) ##1 !retune_pulse) else $error("retune pulse wrong");
    AST_TRIP_LR: assert property (sc_wr
        |=> trip_level.right_ma == ma($past(reg_wdata[14:12]), 25)
        && trip_level.left_ma == ma($past(reg_wdata[10:8]), 25)) else $error("side trip wrong");
    AST_TRIP_C: assert property (sc_wr
        |=> trip_level.center_ma == ma($past(reg_wdata[6:4]), 50))
        else $error("center trip wrong");
    AST_LATCH: assert property ($rose(left_class_a) |-> $past(short_left_async, 2)
        || $past(short_left_async, 3) || $past(short_left_async, 4)) else $error("class A");
    AST_FLAG: assert property (side_short_flag |-> left_class_a || right_class_a
        || $past(short_left_async || short_right_async, 2)
        || $past(short_left_async || short_right_async, 3)) else $error("flag wrong");
endmodule
bind catsc_top catsc_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.*);

/* File: verif/catsc_bench.sv */
// Self-checking bench for the analog tweak and headphone short control bank
`timescale 1ns/10ps
module catsc_bench;
    localparam int unsigned TMO = 20;
    logic                           clock = 1'b0;
    logic                           reset = 1'b1;
    logic                           reg_wr = 1'b0;
    logic                           reg_rd = 1'b0;
    logic [7:0]                     reg_addr = 8'h00;
    logic [15:0]                    reg_wdata = 16'h0000;
    logic [15:0]                    reg_rdata;
    logic                           short_left_async = 1'b0;
    logic                           short_right_async = 1'b0;
    logic                           short_center_async = 1'b0;
    logic                           dac_in_valid = 1'b0;
    logic [catsc_pkg::DAC_W-1:0]    dac_in_left = '0;
    logic [catsc_pkg::DAC_W-1:0]    dac_in_right = '0;
    logic                           dac_out_valid, retune_pulse;
    logic [catsc_pkg::DAC_W-1:0]    dac_out_left, dac_out_right;
    catsc_pkg::catsc_analog_s       analog_ctrl;
    catsc_pkg::catsc_trip_s         trip_level;
    logic                           left_class_a, right_class_a, side_short_flag;
    int                             n_mismatch = 0, samples_checked = 0, tw = 0, sc = 0, k;
    catsc_top #(.TIMEOUT_CYCLES(TMO)) dut (.*);
    initial forever #10 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        test_done();
    end
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Model keeps only writable bits, so reserved bits read back as zero
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (a == 8'h3a) tw = d & 16'h7fff;
        if (a == 8'h3c) sc = d & 16'h777c;
    endtask
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    function automatic int ma(int c, int s);
        return c < 4 ? (4 - c) * s : (c + 1) * s;
    endfunction
    initial begin
        void'($urandom(32'hdff63b2b));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        rd(8'h3a, 16'h0000);
        rd(8'h3c, 16'h0000);
        rd(8'h40, 16'h0000);
        $display("reset test done");
        repeat (8) begin
            wr(8'h3a, 16'($urandom));
            #1 chk(analog_ctrl, tw);
            rd(8'h3a, 16'(tw));
        end
        for (int c = 0; c < 8; c++) begin
            wr(8'h3c, 16'(c * 16'h1110) | 16'h8883);
            #1 chk(trip_level, {8'(ma(c, 25)), 8'(ma(c, 25)), 9'(ma(c, 50))});
            rd(8'h3c, 16'(sc));
        end
        wr(8'h36, 16'hffff);
        rd(8'h36, 16'h0000);
        // Mid-run reset must bring every writable field back to zero
        wr(8'h3a, 16'h1234);
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        tw = 0;
        sc = 0;
        #1 chk(analog_ctrl, tw);
        chk(trip_level, {8'(ma(0, 25)), 8'(ma(0, 25)), 9'(ma(0, 50))});
        rd(8'h3a, 16'(tw));
        rd(8'h3c, 16'(sc));
        $display("register test done");
        for (int m = 0; m < 2; m++) begin
            wr(8'h3a, 16'(m << 12));
            @(posedge clock);
            dac_in_valid <= 1'b1;
            dac_in_left <= 24'($urandom);
            dac_in_right <= 24'($urandom);
            @(posedge clock);
            dac_in_valid <= 1'b0;
            #1 chk(dac_out_right, (m == 1) ? dac_in_left : dac_in_right);
            chk(dac_out_left, dac_in_left);
            chk(dac_out_valid, 1);
            cyc(1);
            chk(dac_out_valid, 0);
            chk(dac_out_right, (m == 1) ? dac_in_left : dac_in_right);
        end
        wr(8'h3a, 16'h0800);
        wr(8'h3a, 16'h0000);
        #1 chk(retune_pulse, 1);
        cyc(1);
        chk(retune_pulse, 0);
        wr(8'h3a, 16'h0000);
        #1 chk(retune_pulse, 0);
        $display("dac and retune test done");
        wr(8'h3c, 16'h000c);
        short_left_async <= 1'b1;
        for (k = 0; k < 8 && left_class_a !== 1'b1; k++) cyc(1);
        chk(k < 8, 1);
        if (k >= 8) test_done();
        short_left_async <= 1'b0;
        cyc(6);
        chk(left_class_a, 1);
        chk(side_short_flag, 1);
        rd(8'h36, 16'h0200);
        wr(8'h3c, 16'h0000);
        cyc(2);
        chk(left_class_a, 0);
        wr(8'h3c, 16'h0004);
        short_right_async <= 1'b1;
        cyc(2);
        short_right_async <= 1'b0;
        cyc(4);
        chk(right_class_a, 1);
        cyc(TMO + 4);
        chk(right_class_a, 0);
        wr(8'h3c, 16'h0000);
        short_left_async <= 1'b1;
        short_center_async <= 1'b1;
        cyc(3);
        chk(side_short_flag, 1);
        chk(left_class_a, 0);
        rd(8'h36, 16'h0300);
        short_left_async <= 1'b0;
        short_center_async <= 1'b0;
        cyc(3);
        chk(side_short_flag, 0);
        $display("short test done");
        test_done();
    end
endmodule
